/* shared/amr_pkg.sv */
// constants and types shared by the converter control block
package amr_pkg;

    // register byte offsets
    localparam logic [7:0] AMR_CHAN_REF_OFF  = 8'h00;
    localparam logic [7:0] AMR_CTRL_OFF      = 8'h04;
    localparam logic [7:0] AMR_MISC_OFF      = 8'h08;
    localparam logic [7:0] AMR_RESULT_OFF    = 8'h0C;
    localparam logic [7:0] AMR_IRQ_STAT_OFF  = 8'h10;
    localparam logic [7:0] AMR_IRQ_MASK_OFF  = 8'h14;

    // channel_ref_select fields
    localparam int AMR_REF_HI_BIT    = 7;
    localparam int AMR_REF_LO_BIT    = 6;
    localparam int AMR_LADJ_BIT      = 5;
    localparam int AMR_CHAN_MSB      = 4;

    // converter_control_status fields
    localparam int AMR_EN_BIT        = 7;
    localparam int AMR_START_BIT     = 6;
    localparam int AMR_FREE_BIT      = 5;
    localparam int AMR_FLAG_BIT      = 4;
    localparam int AMR_IE_BIT        = 3;
    localparam int AMR_DIV_MSB       = 2;

    // analog_misc_control fields
    localparam int AMR_EXT_REF_BIT   = 0;
    localparam int AMR_REF_OUT_BIT   = 1;

    // interrupt status / mask fields
    localparam int AMR_IRQ_DONE_BIT  = 0;
    localparam int AMR_IRQ_ABORT_BIT = 1;

    // reset values
    localparam logic [7:0] AMR_CHAN_REF_RST = 8'h00;
    localparam logic [7:0] AMR_CTRL_RST     = 8'h00;
    localparam logic [1:0] AMR_MISC_RST     = 2'h0;
    localparam logic [1:0] AMR_IRQ_RST      = 2'h0;

    // conversion lengths in converter clock cycles
    localparam logic [4:0] AMR_CYC_INIT = 5'h19;
    localparam logic [4:0] AMR_CYC_NORM = 5'h0D;

    typedef enum logic [1:0]
    {
        AMR_REF_SUPPLY   = 2'h0,
        AMR_REF_EXTERNAL = 2'h1,
        AMR_REF_INT_1V1  = 2'h2,
        AMR_REF_INT_2V56 = 2'h3
    } amr_ref_src_t;

    typedef enum logic [1:0]
    {
        AMR_ST_IDLE = 2'b01,
        AMR_ST_BUSY = 2'b10
    } amr_state_t;

endpackage : amr_pkg

/* shared/amr_clk_if.sv */
// carrier between the control logic and the converter clock prescaler
`timescale 1ns/10ps
interface amr_clk_if;
    logic [2:0] div_sel;
    logic       run;
    logic       tick;

    modport ctrl
    (
        output div_sel,
        output run,
        input  tick
    );

    modport gen
    (
        input  div_sel,
        input  run,
        output tick
    );
endinterface : amr_clk_if

/* rtl/amr_prescaler.sv */
// converter clock prescaler: one-cycle enable pulse every 2..128 system clocks
`timescale 1ns/10ps
module amr_prescaler
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // control side
    amr_clk_if.gen    clk_port
);
    import amr_pkg::*;

    logic [6:0] cnt_q;
    logic [6:0] limit;
    logic       tick_q;

    always_comb
    begin
        if (clk_port.div_sel <= 3'h1)
            limit = 7'h01;
        else
            limit = 7'((8'h01 << clk_port.div_sel) - 8'h01);
    end

    // counter restarts while the converter is off so the first tick is a full period away
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q  <= 7'h00;
            tick_q <= 1'b0;
        end
        else if (!clk_port.run)
        begin
            cnt_q  <= 7'h00;
            tick_q <= 1'b0;
        end
        else if (cnt_q >= limit)
        begin
            cnt_q  <= 7'h00;
            tick_q <= 1'b1;
        end
        else
        begin
            cnt_q  <= cnt_q + 7'h01;
            tick_q <= 1'b0;
        end
    end

    assign clk_port.tick = tick_q;

endmodule : amr_prescaler

/* rtl/amr_top.sv */
// converter control: reference and input selection, start, busy and done over APB
// Overview of operation
// - The reference pin is driven only while the converter is on and ref output is enabled.
// - With ref output on, select 01 gives the 1.1V and 11 the 2.56V reference on the pin.
// - Low select bit 0 picks supply or external pin by the external bit, 01 and 11 internal.
// - A reference change during a conversion takes effect only after that conversion ends.
// - After any reference select change the next conversion lasts 25 converter cycles.
// - The result reads left-adjusted when the left-adjust bit is set, at once.
// - A channel change during a conversion takes effect only after that conversion ends.
// - Channel codes with top bit clear pick single-ended inputs, code 0 1111 reserved.
// - Channel codes with top bit set pick a differential pair by bits 3:1, gain by bit 0.
// - Writing the enable bit switches the converter on or off; off aborts a conversion.
// - Writing one to start begins a conversion; free running needs only the first start.
// - The first conversion after enabling lasts 25 converter cycles, later ones 13 unless the reference select changed.
// - Start reads one while a conversion runs and writing zero to it does nothing.
// - The done flag sets when a result is stored and clears when written with one.
// - The converter clock is the system clock divided by 2 to 128 per the divider field.
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/10ps
module amr_top
(
    // clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // apb slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic                     pready,
    output logic [31:0]              prdata,
    output logic                     pslverr,
    // analog core
    input  wire logic [9:0]          core_result,
    output logic                     core_enable,
    output logic                     core_clk_en,
    output logic                     core_busy,
    output logic                     core_init,
    output amr_pkg::amr_ref_src_t    ref_source,
    output logic                     chan_diff,
    output logic [3:0]               chan_index,
    output logic                     chan_gain_20x,
    // reference output pin
    output logic                     ref_output_pin_oe_n,
    output logic                     ref_output_2v56,
    // interrupt
    output logic                     irq
);
    import amr_pkg::*;

    amr_clk_if  clk_bus ();

    amr_state_t state_q;
    logic [7:0] chan_ref_q;
    logic       en_q;
    logic       free_q;
    logic [2:0] div_q;
    logic [1:0] misc_q;
    logic [1:0] irq_stat_q;
    logic [1:0] irq_mask_q;
    logic [9:0] result_q;
    logic [4:0] cyc_q;
    logic [4:0] len_q;
    logic       init_need_q;
    logic       ref_changed_q;
    logic [2:0] app_ref_q;
    logic [4:0] app_chan_q;
    logic       pready_q;
    logic       pslverr_q;
    logic [31:0] prdata_q;
    logic       irq_q;

    logic       wr;
    logic       wr_ctrl;
    logic       wr_chan;
    logic       en_d;
    logic       start_req;
    logic       conv_end;
    logic       restart;
    logic       abort;
    logic       mapped;
    logic [31:0] rd_d;
    logic [15:0] result_view;

    amr_prescaler u_prescaler
    (
        .pclk     (pclk),
        .presetn  (presetn),
        .clk_port (clk_bus.gen)
    );

    assign clk_bus.div_sel = div_q;
    assign clk_bus.run     = en_q;

    // bus decode; writes take effect at the access edge where pready is high
    assign wr      = psel && penable && pwrite && pready_q;
    assign wr_ctrl = wr && (paddr == AMR_CTRL_OFF);
    assign wr_chan = wr && (paddr == AMR_CHAN_REF_OFF);
    assign en_d    = wr_ctrl ? pwdata[AMR_EN_BIT] : en_q;
    // only a one written to start matters, and only while idle
    assign start_req = wr_ctrl && pwdata[AMR_START_BIT] && pwdata[AMR_EN_BIT]
                       && (state_q == AMR_ST_IDLE);
    assign abort    = (state_q == AMR_ST_BUSY) && !en_d;
    assign conv_end = (state_q == AMR_ST_BUSY) && en_d && clk_bus.tick
                      && (cyc_q == len_q - 5'h01);
    // free running restarts itself after each result
    assign restart  = conv_end && free_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_q <= AMR_ST_IDLE;
        else
        begin
            unique case (state_q)
                AMR_ST_IDLE:
                begin
                    if (start_req)
                        state_q <= AMR_ST_BUSY;
                end
                AMR_ST_BUSY:
                begin
                    if (abort || (conv_end && !restart))
                        state_q <= AMR_ST_IDLE;
                end
                default:
                    state_q <= AMR_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            chan_ref_q <= AMR_CHAN_REF_RST;
            en_q       <= AMR_CTRL_RST[AMR_EN_BIT];
            free_q     <= AMR_CTRL_RST[AMR_FREE_BIT];
            div_q      <= AMR_CTRL_RST[AMR_DIV_MSB:0];
            misc_q     <= AMR_MISC_RST;
            irq_mask_q <= AMR_IRQ_RST;
        end
        else
        begin
            if (wr_chan)
                chan_ref_q <= pwdata[7:0];
            if (wr_ctrl)
            begin
                en_q   <= pwdata[AMR_EN_BIT];
                free_q <= pwdata[AMR_FREE_BIT];
                div_q  <= pwdata[AMR_DIV_MSB:0];
                irq_mask_q[AMR_IRQ_DONE_BIT] <= pwdata[AMR_IE_BIT];
            end
            if (wr && (paddr == AMR_MISC_OFF))
                misc_q <= pwdata[1:0];
            if (wr && (paddr == AMR_IRQ_MASK_OFF))
                irq_mask_q <= pwdata[1:0];
        end
    end

    // initialization pending from enabling until the first conversion starts
    // a write that changes the select bits forces a long conversion next
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            init_need_q   <= 1'b1;
            ref_changed_q <= 1'b0;
        end
        else
        begin
            if (!en_d)
                init_need_q <= 1'b1;
            else if (start_req)
                init_need_q <= 1'b0;
            if (wr_chan && (pwdata[7:6] != chan_ref_q[7:6]))
                ref_changed_q <= 1'b1;
            else if (start_req || restart)
                ref_changed_q <= 1'b0;
        end
    end

    // conversion length and cycle count in converter clocks
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cyc_q <= 5'h00;
            len_q <= AMR_CYC_NORM;
        end
        else if (start_req || restart)
        begin
            cyc_q <= 5'h00;
            len_q <= (init_need_q || ref_changed_q) ? AMR_CYC_INIT : AMR_CYC_NORM;
        end
        else if ((state_q == AMR_ST_BUSY) && clk_bus.tick)
            cyc_q <= cyc_q + 5'h01;
    end

    // reference and channel follow the register only between conversions
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            app_ref_q  <= 3'h0;
            app_chan_q <= 5'h00;
        end
        else if ((state_q == AMR_ST_IDLE && !start_req) || conv_end)
        begin
            app_ref_q  <= {chan_ref_q[AMR_REF_HI_BIT:AMR_REF_LO_BIT], misc_q[AMR_EXT_REF_BIT]};
            app_chan_q <= chan_ref_q[AMR_CHAN_MSB:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            result_q <= 10'h000;
        else if (conv_end)
            result_q <= core_result;
    end

    // done flag: a completion in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_stat_q <= AMR_IRQ_RST;
        else
        begin
            if (conv_end)
                irq_stat_q[AMR_IRQ_DONE_BIT] <= 1'b1;
            else if ((wr_ctrl && pwdata[AMR_FLAG_BIT])
                     || (wr && paddr == AMR_IRQ_STAT_OFF && pwdata[AMR_IRQ_DONE_BIT]))
                irq_stat_q[AMR_IRQ_DONE_BIT] <= 1'b0;
            if (abort)
                irq_stat_q[AMR_IRQ_ABORT_BIT] <= 1'b1;
            else if (wr && paddr == AMR_IRQ_STAT_OFF && pwdata[AMR_IRQ_ABORT_BIT])
                irq_stat_q[AMR_IRQ_ABORT_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_q <= 1'b0;
        else
            irq_q <= |(irq_stat_q & irq_mask_q);
    end

    // layout is applied on read, so a change shows at once
    assign result_view = chan_ref_q[AMR_LADJ_BIT] ? {result_q, 6'h00} : {6'h00, result_q};

    always_comb
    begin
        rd_d   = 32'h0000_0000;
        mapped = 1'b1;
        unique case (paddr)
            AMR_CHAN_REF_OFF: rd_d[7:0]  = chan_ref_q;
            AMR_CTRL_OFF:     rd_d[7:0]  = {en_q, state_q == AMR_ST_BUSY, free_q,
                                            irq_stat_q[AMR_IRQ_DONE_BIT],
                                            irq_mask_q[AMR_IRQ_DONE_BIT], div_q};
            AMR_MISC_OFF:     rd_d[1:0]  = misc_q;
            AMR_RESULT_OFF:   rd_d[15:0] = result_view;
            AMR_IRQ_STAT_OFF: rd_d[1:0]  = irq_stat_q;
            AMR_IRQ_MASK_OFF: rd_d[1:0]  = irq_mask_q;
            default:          mapped     = 1'b0;
        endcase
    end

    // answer in the first access cycle; data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end
        else
        begin
            pready_q  <= psel && !penable;
            pslverr_q <= psel && !penable && !mapped;
            if (psel && !penable && !pwrite)
                prdata_q <= rd_d;
        end
    end

    // outputs toward the analog core and the pin
    amr_ref_src_t ref_src_q;
    logic         core_en_q;
    logic         clk_en_q;
    logic         busy_q;
    logic         init_q;
    logic         diff_q;
    logic [3:0]   index_q;
    logic         gain_q;
    logic         oe_n_q;
    logic         lvl_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ref_src_q <= AMR_REF_SUPPLY;
            core_en_q <= 1'b0;
            clk_en_q  <= 1'b0;
            busy_q    <= 1'b0;
            init_q    <= 1'b0;
            diff_q    <= 1'b0;
            index_q   <= 4'h0;
            gain_q    <= 1'b0;
            oe_n_q    <= 1'b1;
            lvl_q     <= 1'b0;
        end
        else
        begin
            if (!app_ref_q[1])
                ref_src_q <= app_ref_q[0] ? AMR_REF_EXTERNAL : AMR_REF_SUPPLY;
            else
                ref_src_q <= app_ref_q[2] ? AMR_REF_INT_2V56 : AMR_REF_INT_1V1;
            core_en_q <= en_q;
            clk_en_q  <= clk_bus.tick;
            busy_q    <= (state_q == AMR_ST_BUSY);
            init_q    <= (state_q == AMR_ST_BUSY) && (len_q == AMR_CYC_INIT);
            // single-ended index, pair index and gain
            diff_q    <= app_chan_q[4];
            index_q   <= app_chan_q[4] ? {1'b0, app_chan_q[3:1]} : app_chan_q[3:0];
            gain_q    <= app_chan_q[4] && app_chan_q[0];
            // drive only with converter on and output enabled
            // 1.1V for 01, 2.56V for 11; 10 and 00 leave the pin undriven
            oe_n_q    <= !(en_q && misc_q[AMR_REF_OUT_BIT] && app_ref_q[1]);
            lvl_q     <= app_ref_q[2];
        end
    end

    assign pready              = pready_q;
    assign pslverr             = pslverr_q;
    assign prdata              = prdata_q;
    assign core_enable         = core_en_q;
    assign core_clk_en         = clk_en_q;
    assign core_busy           = busy_q;
    assign core_init           = init_q;
    assign ref_source          = ref_src_q;
    assign chan_diff           = diff_q;
    assign chan_index          = index_q;
    assign chan_gain_20x       = gain_q;
    assign ref_output_pin_oe_n = oe_n_q;
    assign ref_output_2v56     = lvl_q;
    assign irq                 = irq_q;

endmodule : amr_top

/* tb/amr_top_monitor.sv */
// assertion checker for the converter control block, bound to its top
`timescale 1ns/10ps
module amr_top_monitor
(
    // clock and reset
    input wire logic                  pclk,
    input wire logic                  presetn,
    // apb
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pready,
    input wire logic                  pslverr,
    // core side
    input wire logic                  core_enable,
    input wire logic                  core_clk_en,
    input wire logic                  core_busy,
    input wire logic                  core_init,
    input wire amr_pkg::amr_ref_src_t ref_source,
    input wire logic                  chan_diff,
    input wire logic [3:0]            chan_index,
    input wire logic                  ref_output_pin_oe_n
);
    import amr_pkg::*;
    logic [5:0] tick_q;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // cleared while idle, so an aborted conversion never spills into the next count
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tick_q <= 6'h00;
        else if (!core_busy)
            tick_q <= 6'h00;
        else if (core_clk_en)
            tick_q <= tick_q + 6'h01;
    end
    a_apb_zero_wait: assert property (psel && !penable |=> pready)
        else $error("no ready in first access cycle");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside an access phase");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("slave error without ready");
    a_pin_needs_on: assert property (!ref_output_pin_oe_n |-> core_enable || $past(core_enable))
        else $error("reference pin driven while converter off");
    a_pin_off_released: assert property ($fell(core_enable) |-> ##[0:2] ref_output_pin_oe_n)
        else $error("reference pin still driven after disable");
    a_chan_hold_busy: assert property (core_busy && $past(core_busy) |->
        $stable({chan_diff, chan_index}) or ##1 !core_busy)
        else $error("channel changed during a conversion");
    a_ref_hold_busy: assert property (core_busy && $past(core_busy) |->
        $stable(ref_source) or ##1 !core_busy)
        else $error("reference changed during a conversion");
    a_conv_length: assert property ($fell(core_busy) && core_enable && $past(core_enable, 2) |->
        tick_q == ($past(core_init) ? 6'h19 : 6'h0D))
        else $error("conversion length wrong");
    a_abort_idle: assert property ($fell(core_enable) |-> ##[0:2] !core_busy)
        else $error("conversion not aborted on disable");
    a_diff_pairs: assert property (chan_diff |-> !chan_index[3])
        else $error("differential pair out of range");
endmodule : amr_top_monitor

bind amr_top amr_top_monitor u_mon (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
    .core_enable, .core_clk_en, .core_busy, .core_init, .ref_source, .chan_diff, .chan_index,
    .ref_output_pin_oe_n);

/* tb/amr_core_model.sv */
// analog core stand-in: returns a code built from the applied selection
`timescale 1ns/10ps
module amr_core_model
(
    // from the control block
    input wire logic                  core_enable,
    input wire logic                  core_busy,
    input wire amr_pkg::amr_ref_src_t ref_source,
    input wire logic                  chan_diff,
    input wire logic [3:0]            chan_index,
    input wire logic                  chan_gain_20x,
    // result
    output logic [9:0]                core_result
);
    import amr_pkg::*;
    logic [9:0] code;
    assign code = {chan_diff, chan_index, chan_gain_20x, 2'h0, ref_source};
    // inverted outside a conversion, so a sample taken at the wrong moment shows up
    assign core_result = (core_enable && core_busy) ? code : ~code;
endmodule : amr_core_model

/* tb/amr_top_test.sv */
// self-checking bench for the converter control block
`timescale 1ns/10ps
module amr_top_test;
    import amr_pkg::*;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic         core_enable, core_clk_en, core_busy, core_init, chan_diff, chan_gain_20x;
    logic         ref_output_pin_oe_n, ref_output_2v56, irq;
    logic [7:0]   paddr;
    logic [31:0]  pwdata, prdata, rd;
    logic [9:0]   core_result;
    logic [3:0]   chan_index;
    amr_ref_src_t ref_source;
    int           bad_count, num_checks, cyc;
    logic [7:0]   t_chan [5] = '{8'h0B, 8'h0B, 8'h4B, 8'hCB, 8'hCB};
    logic [1:0]   t_misc [5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h2};
    amr_ref_src_t t_ref  [5] = '{AMR_REF_SUPPLY, AMR_REF_EXTERNAL, AMR_REF_INT_1V1,
                                 AMR_REF_INT_2V56, AMR_REF_INT_2V56};
    logic         t_oe   [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    logic         t_hi   [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    int           t_len  [5] = '{13, 13, 25, 25, 13};

    amr_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
        .pslverr, .core_result, .core_enable, .core_clk_en, .core_busy, .core_init, .ref_source,
        .chan_diff, .chan_index, .chan_gain_20x, .ref_output_pin_oe_n, .ref_output_2v56, .irq);
    amr_core_model core (.core_enable, .core_busy, .ref_source, .chan_diff, .chan_index,
        .chan_gain_20x, .core_result);

    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic check_bit(input logic got, input logic exp);
        check({31'h0, got}, {31'h0, exp});
    endtask : check_bit

    task automatic check_span(input int got, input int lo, input int hi);
        num_checks++;
        if (got < lo || got > hi)
        begin
            bad_count++;
            $display("ERROR at %0t: got %h expected %h..%h", $time, got, lo, hi);
        end
    endtask : check_span

    // apb transfer: hold everything until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
        begin
            bad_count++;
            stop_test();
        end
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rdchk

    // a stale level from the previous flag is let go first; cycles count from entry
    task automatic wait_irq;
        cyc = 0;
        while (irq === 1'b1 && cyc < 8)
        begin
            @(posedge pclk);
            cyc++;
        end
        while (irq !== 1'b1 && cyc < 2000)
        begin
            @(posedge pclk);
            cyc++;
        end
        if (cyc >= 2000)
        begin
            bad_count++;
            stop_test();
        end
    endtask : wait_irq

    function automatic logic [31:0] res(logic d, logic [3:0] i, logic g, amr_ref_src_t r);
        return {22'h0, d, i, g, 2'h0, r};
    endfunction : res

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        bad_count = 0;
        num_checks = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(AMR_CHAN_REF_OFF, 32'h0);
        rdchk(AMR_CTRL_OFF, 32'h0);
        rdchk(AMR_MISC_OFF, 32'h0);
        check_bit(ref_output_pin_oe_n, 1'b1);
        apb(1'b0, 8'h20, 32'h0);
        check(rd, 32'h0);
        check_bit(err, 1'b1);
        wr(AMR_CHAN_REF_OFF, 32'hA5);
        rdchk(AMR_CHAN_REF_OFF, 32'hA5);
        wr(AMR_IRQ_MASK_OFF, 32'h1);
        rdchk(AMR_CTRL_OFF, 32'h08);
        wr(AMR_CHAN_REF_OFF, 32'h13);
        wr(AMR_CTRL_OFF, 32'hC8);
        wait_irq;
        check_span(cyc, 48, 54);
        check_bit(core_busy, 1'b0);
        rdchk(AMR_CTRL_OFF, 32'h98);
        rdchk(AMR_IRQ_STAT_OFF, 32'h1);
        check({26'h0, chan_diff, chan_index, chan_gain_20x}, 32'h23);
        rdchk(AMR_RESULT_OFF, res(1'b1, 4'h1, 1'b1, AMR_REF_SUPPLY));
        wr(AMR_CHAN_REF_OFF, 32'h32);
        rdchk(AMR_RESULT_OFF, res(1'b1, 4'h1, 1'b1, AMR_REF_SUPPLY) << 6);
        check({26'h0, chan_diff, chan_index, chan_gain_20x}, 32'h22);
        wr(AMR_CHAN_REF_OFF, 32'h13);
        wr(AMR_IRQ_STAT_OFF, 32'h1);
        rdchk(AMR_CTRL_OFF, 32'h88);
        wr(AMR_CTRL_OFF, 32'hC8);
        rdchk(AMR_CTRL_OFF, 32'hC8);
        wr(AMR_CHAN_REF_OFF, 32'h0B);
        wr(AMR_CTRL_OFF, 32'h88);
        rdchk(AMR_CTRL_OFF, 32'hC8);
        wait_irq;
        rdchk(AMR_RESULT_OFF, res(1'b1, 4'h1, 1'b1, AMR_REF_SUPPLY));
        check({27'h0, chan_diff, chan_index}, 32'h0B);
        for (int k = 0; k < 8; k++)
        begin
            wr(AMR_CTRL_OFF, 32'hD8 | k);
            wait_irq;
            check_span(cyc, 12 * ((k < 2) ? 2 : (1 << k)), 13 * ((k < 2) ? 2 : (1 << k)) + 4);
        end
        for (int i = 0; i < 5; i++)
        begin
            wr(AMR_MISC_OFF, {30'h0, t_misc[i]});
            wr(AMR_CHAN_REF_OFF, {24'h0, t_chan[i]});
            wr(AMR_CTRL_OFF, 32'hD8);
            wait_irq;
            if (t_len[i] != 0)
                check_span(cyc, (t_len[i] - 1) * 2, t_len[i] * 2 + 4);
            check({30'h0, ref_source}, {30'h0, t_ref[i]});
            check_bit(ref_output_pin_oe_n, t_oe[i]);
            if (!t_oe[i])
                check_bit(ref_output_2v56, t_hi[i]);
        end
        wr(AMR_CTRL_OFF, 32'hD8);
        wr(AMR_CHAN_REF_OFF, 32'h4B);
        wait_irq;
        rdchk(AMR_RESULT_OFF, res(1'b0, 4'hB, 1'b0, AMR_REF_INT_2V56));
        check({30'h0, ref_source}, {30'h0, AMR_REF_INT_1V1});
        wr(AMR_CTRL_OFF, 32'hF8);
        wait_irq;
        check_span(cyc, 48, 54);
        wr(AMR_IRQ_STAT_OFF, 32'h1);
        wait_irq;
        check_bit(irq, 1'b1);
        wr(AMR_IRQ_STAT_OFF, 32'h1);
        wr(AMR_CTRL_OFF, 32'h08);
        rdchk(AMR_IRQ_STAT_OFF, 32'h2);
        check_bit(core_busy, 1'b0);
        check_bit(ref_output_pin_oe_n, 1'b1);
        check_bit(irq, 1'b0);
        wr(AMR_IRQ_MASK_OFF, 32'h3);
        repeat (2) @(posedge pclk);
        check_bit(irq, 1'b1);
        wr(AMR_IRQ_STAT_OFF, 32'h2);
        repeat (2) @(posedge pclk);
        check_bit(irq, 1'b0);
        stop_test();
    end
endmodule : amr_top_test
